// ---- sim/boundary_scan_tap_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_test;
	// Clock, reset and test port
	logic        clk;
	logic        srst;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic        tdo_oe;
	logic [31:0] id_par;
	// Core side and pins
	logic [7:0]  core_out;
	logic        core_oe;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic        pin_oe;
	// Counters and model state
	int          num_errors;
	int          cmp_count;
	int          cur_ir;
	logic        oe_seen;
	logic [16:0] bsr_latch;
	logic [63:0] r;
	logic [63:0] r2;
	logic [63:0] d;

	bst_tap dut (.clk(clk), .srst(srst), .test_clock_pin(tck), .test_mode_select_pin(tms),
		.test_data_in_pin(tdi), .test_data_out_pin(tdo), .test_data_out_oe(tdo_oe),
		.id_parallel(id_par), .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe));
	bst_tester tb (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	// System clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////
	// Compare and count
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Counts, verdict, end of run
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// One test clock, serial in random
	task automatic go(input logic m);
		logic o;
		tb.cyc(m, 1'($urandom), o, oe_seen);
	endtask
	// n shift cycles, LSB first; mode select high on the last when ex
	task automatic shift(input int n, input logic [63:0] din, input logic ex,
		output logic [63:0] dout);
		logic o;
		logic e;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			tb.cyc(ex && i == n - 1, din[i], o, e);
			dout[i] = o;
			check(64'(e), 64'h1);
		end
	endtask
	////////////////////////////////////////
	// Model: length of the register the current instruction selects
	function automatic int dr_len();
		case (cur_ir)
			1: return 32;
			0, 2: return 17;
			default: return 1;
		endcase
	endfunction
	// Instruction scan from idle back to idle
	task automatic scan_ir(input int code);
		go(1'b1);
		go(1'b1);
		go(1'b0);
		go(1'b0);
		shift(3, 64'(code), 1'b1, r);
		check(r, 64'(bst_pkg::IR_CAPTURE));
		go(1'b1);
		go(1'b0);
		cur_ir = code;
	endtask
	// Data scan of n bits from idle; output and latches follow the model
	task automatic scan_dr(input int n, input logic [63:0] din);
		logic [127:0] full;
		logic [63:0]  regv;
		full = 128'h0;
		if (cur_ir == 1) full = 128'(bst_pkg::ID_WORD);
		if (cur_ir == 0 || cur_ir == 2) full = 128'({core_oe, core_out, pin_in});
		full = full | (128'(din) << dr_len());
		go(1'b1);
		go(1'b0);
		go(1'b0);
		shift(n, din, 1'b1, r);
		check(r, full[63:0] & ((64'h1 << n) - 64'h1));
		go(1'b1);
		go(1'b0);
		regv = 64'(full >> n);
		if (dr_len() == 17) bsr_latch = regv[16:0];
		if (cur_ir == 1) check(64'(id_par), regv & 64'hffffffff);
	endtask
	// Pins once the crossing has settled
	task automatic chk_pins();
		repeat (10) @(negedge clk);
		if (cur_ir == 0 || cur_ir == 3) begin
			check(64'({pin_oe, pin_out}), 64'(bsr_latch[16:8]));
		end else if (cur_ir == 4) begin
			check(64'(pin_oe), 64'h0);
		end else begin
			check(64'({pin_oe, pin_out}), 64'({core_oe, core_out}));
		end
		#1.3;
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		srst = 1'b1;
		core_out = 8'h00;
		core_oe = 1'b0;
		pin_in = 8'h00;
		num_errors = 0;
		cmp_count = 0;
		cur_ir = 1;
		bsr_latch = '0;
		void'($urandom(50));
		repeat (5) @(negedge clk);
		#1.3;
		// Reset must also reach the test clock domain
		repeat (5) go(1'b1);
		@(negedge clk);
		srst = 1'b0;
		#1.3;
		repeat (3) go(1'b1);
		go(1'b0);
		check(64'(id_par), 64'(bst_pkg::ID_WORD));
		chk_pins();
		scan_dr(32, {$urandom, $urandom});
		// Every instruction code, a data scan and a look at the pins
		for (int c = 0; c < 8; c++) begin
			@(negedge clk);
			core_out = 8'($urandom);
			core_oe = 1'($urandom);
			pin_in = 8'($urandom);
			#1.3;
			scan_ir(c);
			scan_dr(40, {$urandom, $urandom});
			chk_pins();
		end
		// Identification scan paused, resumed, ended from the second exit
		scan_ir(1);
		d = {$urandom, $urandom};
		go(1'b1);
		go(1'b0);
		go(1'b0);
		shift(10, d, 1'b1, r);
		go(1'b0);
		go(1'b0);
		check(64'(oe_seen), 64'h0);
		go(1'b1);
		go(1'b0);
		shift(22, d >> 10, 1'b1, r2);
		go(1'b0);
		go(1'b1);
		go(1'b1);
		go(1'b0);
		check(64'({r2[21:0], r[9:0]}), 64'(bst_pkg::ID_WORD));
		check(64'(id_par), d & 64'hffffffff);
		// Instruction scan through pause, back into shift from the second exit
		go(1'b1);
		go(1'b1);
		go(1'b0);
		go(1'b0);
		shift(1, 64'h1, 1'b1, r);
		go(1'b0);
		go(1'b1);
		go(1'b0);
		shift(2, 64'h3, 1'b1, r2);
		go(1'b1);
		go(1'b0);
		cur_ir = 7;
		check(64'({r2[1:0], r[0]}), 64'(bst_pkg::IR_CAPTURE));
		scan_dr(8, 64'($urandom));
		// Clamp, then reset through select-IR: pins go back to the core
		scan_ir(3);
		go(1'b1);
		go(1'b1);
		go(1'b1);
		go(1'b0);
		cur_ir = 1;
		chk_pins();
		scan_dr(32, {$urandom, $urandom});
		give_verdict();
	end
	// Hang guard
	initial begin
		#200us;
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire

// ---- sim/bst_tester.sv ----
`timescale 1ns/1ps
`default_nettype none
// Test controller model: the test clock runs only while a cycle is asked for
module bst_tester (
	// Test port, driven side
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	// Test port, returned side
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	////////////////////////////////////////
	// Parked: clock low, mode select high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	////////////////////////////////////////
	// One test clock: levels set after a fall, serial out and its enable
	// taken at the rise, where both have settled since the previous fall
	task automatic cyc(input logic m, input logic d, output logic o, output logic e);
		tms = m;
		tdi = d;
		#7.5 tck = 1'b1;
		o = tdo;
		e = tdo_oe;
		#7.5 tck = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- src/bst_pkg.sv ----
// Operation
// RL1: Power-up in reset state, identification instruction current
// RL2: Mode select sampled on rising test clock
// RL3: Select-DR goes capture-DR or select-IR
// RL4: Capture-DR loads selected register, then shift/exit1
// RL5: Shift-DR shifts selected register toward serial out
// RL6: Exit1-DR to update/pause; pause holds until high
// RL7: Exit2-DR to update-DR high, shift-DR low
// RL8: Update-DR falling edge loads output latches
// RL9: Select-IR goes capture-IR or back to reset
// RL10: Capture-IR loads fixed pattern, then shift/exit1
// RL11: Shift-IR shifts 3-bit instruction register
// RL12: Exit1-IR low to pause-IR; pause holds
// RL13: Exit1-IR or exit2-IR high enters update-IR
// RL14: Update-IR falling edge makes instruction current
// RL15: Codes 010 sample, 111 bypass, 000 extest
// RL16: Codes 011 clamp, 100 highz, 001 identification
// RL17: Sample captures pins without disturbing operation
// RL18: Bypass uses single-stage bypass register
// RL19: Extest drives outputs from boundary latches
// RL20: Clamp holds latched outputs; highz floats outputs
// RL21: Identification code loaded in capture-DR, shifted out
// RL22: Identification word: 1, maker, device, version
// RL23: 32-bit identification shift register with latch
// RL24: Capture-IR pattern has 01 in low bits
// RL25: Exit2-IR with mode select low returns shift-IR
package bst_pkg;
	// Instruction register
	localparam int         IR_LEN       = 3;
	localparam logic [2:0] IR_EXTEST    = 3'h0;
	localparam logic [2:0] IR_IDCODE    = 3'h1;
	localparam logic [2:0] IR_SAMPLE    = 3'h2;
	localparam logic [2:0] IR_CLAMP     = 3'h3;
	localparam logic [2:0] IR_HIGHZ     = 3'h4;
	localparam logic [2:0] IR_BYPASS    = 3'h7;
	localparam logic [2:0] IR_CAPTURE   = 3'h1;
	// Identification word fields, values arbitrary
	localparam logic [3:0]  ID_VERSION  = 4'h1;
	localparam logic [15:0] ID_DEVICE   = 16'h5a3c;
	localparam logic [10:0] ID_MAKER    = 11'h2aa;
	localparam int          ID_LEN      = 32;
	localparam logic [31:0] ID_WORD     = {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};
	// Boundary register layout: inputs, outputs, one enable cell
	localparam int N_IN    = 8;
	localparam int N_OUT   = 8;
	localparam int BSR_IN  = 0;
	localparam int BSR_OUT = N_IN;
	localparam int BSR_OE  = N_IN + N_OUT;
	localparam int BSR_LEN = N_IN + N_OUT + 1;
	// Controller states
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} bst_state_t;
endpackage

// ---- src/bst_tap.sv ----
`timescale 1ns/1ps
`default_nettype none
module bst_tap (
	// System clock and reset
	input  wire logic                        clk,
	input  wire logic                        srst,
	// Test access port
	input  wire logic                        test_clock_pin,
	input  wire logic                        test_mode_select_pin,
	input  wire logic                        test_data_in_pin,
	output logic                             test_data_out_pin,
	output logic                             test_data_out_oe,
	output logic [bst_pkg::ID_LEN-1:0]       id_parallel,
	// Core logic side
	input  wire logic [bst_pkg::N_OUT-1:0]   core_out,
	input  wire logic                        core_oe,
	// Device pins
	input  wire logic [bst_pkg::N_IN-1:0]    pin_in,
	output logic [bst_pkg::N_OUT-1:0]        pin_out,
	output logic                             pin_oe
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic                        rst_s1;       // Reset synchroniser, first stage
	logic                        tck_rst;      // Reset in test clock domain
	bst_pkg::bst_state_t         state;        // Controller state
	bst_pkg::bst_state_t         next_state;   // Controller next state
	logic [bst_pkg::IR_LEN-1:0]  ir_shift;     // Instruction shift stage
	logic [bst_pkg::IR_LEN-1:0]  ir_cur;       // Current instruction latch
	logic                        byp;          // Bypass stage
	logic [bst_pkg::ID_LEN-1:0]  id_shift;     // Identification shift stage
	logic [bst_pkg::BSR_LEN-1:0] bsr_shift;    // Boundary shift stage
	logic [bst_pkg::BSR_LEN-1:0] bsr_upd;      // Boundary output latches
	logic [bst_pkg::N_IN-1:0]    in_s1;        // Pin input sync, first stage
	logic [bst_pkg::N_IN-1:0]    in_s2;        // Pin input sync, second stage
	logic [bst_pkg::N_OUT:0]     cor_s1;       // Core output sync, first stage
	logic [bst_pkg::N_OUT:0]     cor_s2;       // Core output sync, second stage
	logic                        upd_tog;      // Toggles when latches change
	logic                        tog_s1;       // Toggle sync, first stage
	logic                        tog_s2;       // Toggle sync, second stage
	logic                        tog_s3;       // Toggle sync, edge history
	logic                        drive_q;      // Pins driven from latches
	logic                        float_q;      // Pins floated
	logic [bst_pkg::BSR_LEN-1:0] bsr_q;        // Latches seen in system domain
	logic                        sel_bsr;      // Boundary register selected
	logic                        sel_id;       // Identification register selected
	logic                        dr_lsb;       // Serial end of selected register
	logic                        tms;          // Mode select level
	logic                        tdi;          // Serial data level

	// Tester drives these before each rising test clock edge
	assign tms = test_mode_select_pin;
	assign tdi = test_data_in_pin;

	////////////////////////////////////////////////////////////////////////
	// Reset into the test clock domain

	// Two stages; the test clock must run while srst is held
	always_ff @(posedge test_clock_pin) begin
		rst_s1  <= srst;
		tck_rst <= rst_s1;
	end

	////////////////////////////////////////////////////////////////////////
	// Controller

	// State register, reset lands in test-logic-reset
	always_ff @(posedge test_clock_pin) begin
		if (tck_rst) begin
			state <= bst_pkg::TLR; // see RL1
		end else begin
			state <= next_state; // see RL2
		end
	end

	// Next state from the mode select level
	always_comb begin
		next_state = state;
		case (state)
			bst_pkg::TLR:    next_state = tms ? bst_pkg::TLR    : bst_pkg::RTI;
			bst_pkg::RTI:    next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_DR: next_state = tms ? bst_pkg::SEL_IR : bst_pkg::CAP_DR; // see RL3
			bst_pkg::CAP_DR: next_state = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;  // see RL4
			bst_pkg::SH_DR:  next_state = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			bst_pkg::EX1_DR: next_state = tms ? bst_pkg::UPD_DR : bst_pkg::PA_DR;  // see RL6
			bst_pkg::PA_DR:  next_state = tms ? bst_pkg::EX2_DR : bst_pkg::PA_DR;  // see RL6
			bst_pkg::EX2_DR: next_state = tms ? bst_pkg::UPD_DR : bst_pkg::SH_DR;  // see RL7
			bst_pkg::UPD_DR: next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_IR: next_state = tms ? bst_pkg::TLR    : bst_pkg::CAP_IR; // see RL9
			bst_pkg::CAP_IR: next_state = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;  // see RL10
			bst_pkg::SH_IR:  next_state = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;  // see RL11
			bst_pkg::EX1_IR: next_state = tms ? bst_pkg::UPD_IR : bst_pkg::PA_IR;  // see RL12
			bst_pkg::PA_IR:  next_state = tms ? bst_pkg::EX2_IR : bst_pkg::PA_IR;  // see RL12
			// Low goes back to shifting, high to update
			bst_pkg::EX2_IR: next_state = tms ? bst_pkg::UPD_IR : bst_pkg::SH_IR;  // see RL13 RL25
			bst_pkg::UPD_IR: next_state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;    // see RL14
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction register

	// Shift stage: fixed pattern on capture, shift toward serial out
	always_ff @(posedge test_clock_pin) begin
		if (tck_rst) begin
			ir_shift <= bst_pkg::IR_CAPTURE;
		end else if (state == bst_pkg::CAP_IR) begin
			ir_shift <= bst_pkg::IR_CAPTURE; // see RL10 RL24
		end else if (state == bst_pkg::SH_IR) begin
			ir_shift <= {tdi, ir_shift[2:1]}; // see RL11
		end
	end

	// Current instruction, latched on the falling edge
	always_ff @(negedge test_clock_pin) begin
		if (tck_rst || state == bst_pkg::TLR) begin
			ir_cur <= bst_pkg::IR_IDCODE; // see RL1
		end else if (state == bst_pkg::UPD_IR) begin
			ir_cur <= ir_shift; // see RL14
		end
	end

	// Decode; unlisted codes fall back to bypass
	assign sel_bsr = (ir_cur == bst_pkg::IR_SAMPLE) || (ir_cur == bst_pkg::IR_EXTEST); // see RL15
	assign sel_id  = (ir_cur == bst_pkg::IR_IDCODE); // see RL16 RL23

	////////////////////////////////////////////////////////////////////////
	// Data registers

	// Bypass stage: zero on capture, one stage in shift
	always_ff @(posedge test_clock_pin) begin
		if (tck_rst) begin
			byp <= 1'b0;
		end else if (!sel_bsr && !sel_id) begin
			if (state == bst_pkg::CAP_DR) begin
				byp <= 1'b0;
			end else if (state == bst_pkg::SH_DR) begin
				byp <= tdi; // see RL18 RL20
			end
		end
	end

	// Identification shift stage
	always_ff @(posedge test_clock_pin) begin
		if (tck_rst) begin
			id_shift <= bst_pkg::ID_WORD;
		end else if (sel_id) begin
			if (state == bst_pkg::CAP_DR) begin
				id_shift <= bst_pkg::ID_WORD; // see RL21 RL22
			end else if (state == bst_pkg::SH_DR) begin
				id_shift <= {tdi, id_shift[bst_pkg::ID_LEN-1:1]}; // see RL5 RL21
			end
		end
	end

	// Identification parallel latch
	always_ff @(negedge test_clock_pin) begin
		if (tck_rst) begin
			id_parallel <= bst_pkg::ID_WORD;
		end else if (sel_id && state == bst_pkg::UPD_DR) begin
			id_parallel <= id_shift; // see RL23
		end
	end

	// Pins and core outputs, two stages before capture reads them
	always_ff @(posedge test_clock_pin) begin
		in_s1  <= pin_in;
		in_s2  <= in_s1;
		cor_s1 <= {core_oe, core_out};
		cor_s2 <= cor_s1;
	end

	// Boundary shift stage: capture pins, shift tester data
	always_ff @(posedge test_clock_pin) begin
		if (tck_rst) begin
			bsr_shift <= '0;
		end else if (sel_bsr) begin
			if (state == bst_pkg::CAP_DR) begin
				bsr_shift <= {cor_s2, in_s2}; // see RL4 RL17 RL19
			end else if (state == bst_pkg::SH_DR) begin
				bsr_shift <= {tdi, bsr_shift[bst_pkg::BSR_LEN-1:1]}; // see RL5 RL17
			end
		end
	end

	// Boundary output latches; pause and shift never reach them
	always_ff @(negedge test_clock_pin) begin
		if (tck_rst) begin
			bsr_upd <= '0;
		end else if (sel_bsr && state == bst_pkg::UPD_DR) begin
			bsr_upd <= bsr_shift; // see RL8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial output

	// Serial end of the selected data register
	always_comb begin
		if (sel_bsr) begin
			dr_lsb = bsr_shift[0];
		end else if (sel_id) begin
			dr_lsb = id_shift[0];
		end else begin
			dr_lsb = byp;
		end
	end

	// Output changes on the falling edge, enabled only while shifting
	always_ff @(negedge test_clock_pin) begin
		if (tck_rst) begin
			test_data_out_pin <= 1'b0;
			test_data_out_oe  <= 1'b0;
		end else if (state == bst_pkg::SH_DR) begin
			test_data_out_pin <= dr_lsb; // see RL5
			test_data_out_oe  <= 1'b1;
		end else if (state == bst_pkg::SH_IR) begin
			test_data_out_pin <= ir_shift[0]; // see RL11
			test_data_out_oe  <= 1'b1;
		end else begin
			test_data_out_oe  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Crossing of latches and instruction into the system domain

	// Toggle on each change of latches or current instruction
	always_ff @(negedge test_clock_pin) begin
		if (tck_rst) begin
			upd_tog <= 1'b0;
		end else if (state == bst_pkg::UPD_IR || (sel_bsr && state == bst_pkg::UPD_DR)) begin
			upd_tog <= ~upd_tog;
		end else if (state == bst_pkg::TLR && !sel_id) begin
			upd_tog <= ~upd_tog;
		end
	end

	// Toggle synchroniser and edge history
	always_ff @(posedge clk) begin
		if (srst) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
		end else begin
			tog_s1 <= upd_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
		end
	end

	// Copy the now settled latches and mode on each toggle edge
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_q <= 1'b0;
			float_q <= 1'b0;
			bsr_q   <= '0;
		end else if (tog_s2 ^ tog_s3) begin
			drive_q <= (ir_cur == bst_pkg::IR_EXTEST) || (ir_cur == bst_pkg::IR_CLAMP);
			float_q <= (ir_cur == bst_pkg::IR_HIGHZ);
			bsr_q   <= bsr_upd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers

	// Core path in normal use, latches under extest and clamp
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_out <= '0;
			pin_oe  <= 1'b0;
		end else if (float_q) begin
			pin_out <= core_out;
			pin_oe  <= 1'b0; // see RL20
		end else if (drive_q) begin
			pin_out <= bsr_q[bst_pkg::BSR_OE-1:bst_pkg::BSR_OUT]; // see RL19 RL20
			pin_oe  <= bsr_q[bst_pkg::BSR_OE];
		end else begin
			pin_out <= core_out; // see RL17 RL18
			pin_oe  <= core_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_seldr;
		@(posedge test_clock_pin) disable iff (tck_rst)
		state == bst_pkg::SEL_DR |=> state == (($past(tms)) ? bst_pkg::SEL_IR : bst_pkg::CAP_DR);
	endproperty
	a_seldr: assert property (p_seldr) else $error("select-DR exit wrong"); // see RL3

	property p_capdr;
		@(posedge test_clock_pin) disable iff (tck_rst)
		(state == bst_pkg::CAP_DR && !tms) |=> state == bst_pkg::SH_DR;
	endproperty
	a_capdr: assert property (p_capdr) else $error("capture-DR to shift-DR failed"); // see RL4

	property p_ex1dr;
		@(posedge test_clock_pin) disable iff (tck_rst)
		(state == bst_pkg::EX1_DR && tms) |=> state == bst_pkg::UPD_DR;
	endproperty
	a_ex1dr: assert property (p_ex1dr) else $error("exit1-DR to update-DR failed"); // see RL6

	property p_ex2dr;
		@(posedge test_clock_pin) disable iff (tck_rst)
		(state == bst_pkg::EX2_DR && !tms) |=> state == bst_pkg::SH_DR;
	endproperty
	a_ex2dr: assert property (p_ex2dr) else $error("exit2-DR did not resume shift"); // see RL7

	property p_selir;
		@(posedge test_clock_pin) disable iff (tck_rst)
		(state == bst_pkg::SEL_IR && tms) |=> state == bst_pkg::TLR;
	endproperty
	a_selir: assert property (p_selir) else $error("select-IR did not reset"); // see RL9

	property p_capir;
		@(posedge test_clock_pin) disable iff (tck_rst)
		state == bst_pkg::CAP_IR |=> ir_shift == bst_pkg::IR_CAPTURE;
	endproperty
	a_capir: assert property (p_capir) else $error("capture-IR pattern missing"); // see RL10

	property p_shir;
		@(posedge test_clock_pin) disable iff (tck_rst)
		state == bst_pkg::SH_IR |=> ir_shift == {$past(tdi), $past(ir_shift[2:1])};
	endproperty
	a_shir: assert property (p_shir) else $error("instruction shift wrong"); // see RL11

	property p_ex2ir;
		@(posedge test_clock_pin) disable iff (tck_rst)
		(state == bst_pkg::EX2_IR && !tms) |=> state == bst_pkg::SH_IR;
	endproperty
	a_ex2ir: assert property (p_ex2ir) else $error("exit2-IR did not resume shift"); // see RL25

	property p_tlrid;
		@(posedge test_clock_pin) disable iff (tck_rst)
		state == bst_pkg::TLR |=> ir_cur == bst_pkg::IR_IDCODE;
	endproperty
	a_tlrid: assert property (p_tlrid) else $error("reset state lost identification"); // see RL1

	property p_idcap;
		@(posedge test_clock_pin) disable iff (tck_rst)
		(sel_id && state == bst_pkg::CAP_DR) |=> id_shift == bst_pkg::ID_WORD;
	endproperty
	a_idcap: assert property (p_idcap) else $error("identification not captured"); // see RL21

	property p_byp;
		@(posedge test_clock_pin) disable iff (tck_rst)
		(ir_cur == bst_pkg::IR_BYPASS && state == bst_pkg::SH_DR) |=> byp == $past(tdi);
	endproperty
	a_byp: assert property (p_byp) else $error("bypass stage wrong"); // see RL18

	property p_hold;
		@(posedge test_clock_pin) disable iff (tck_rst)
		state == bst_pkg::PA_DR |=> $stable(bsr_shift) && $stable(id_shift);
	endproperty
	a_hold: assert property (p_hold) else $error("pause-DR moved a register"); // see RL6

	property p_float;
		@(posedge clk) disable iff (srst)
		float_q |=> !pin_oe;
	endproperty
	a_float: assert property (p_float) else $error("pins not floated"); // see RL20

	c_idscan: cover property (@(posedge test_clock_pin) disable iff (tck_rst)
		sel_id && state == bst_pkg::SH_DR ##1 state == bst_pkg::EX1_DR);
	c_irupd: cover property (@(posedge test_clock_pin) disable iff (tck_rst)
		state == bst_pkg::UPD_IR ##1 state == bst_pkg::RTI);
	c_pausir: cover property (@(posedge test_clock_pin) disable iff (tck_rst)
		state == bst_pkg::EX2_IR ##1 state == bst_pkg::SH_IR);
	c_extest: cover property (@(posedge clk) disable iff (srst) drive_q ##1 pin_oe);

endmodule
`default_nettype wire
